// ### src/dss_pkg.sv
/*
 package for the converter start-up sequencer: register offsets, values, step kinds,
 step indices and serial port timing. assumes a 4-wire serial port on the device.
*/
package dss_pkg;
    localparam logic [14:0] REG_IFACE_CFG = 15'h0000;
    localparam logic [14:0] REG_BIAS_PWR = 15'h0011;
    localparam logic [14:0] REG_CLK_PWR = 15'h0080;
    localparam logic [14:0] REG_SYNC_PWR = 15'h0081;
    localparam logic [14:0] REG_PLL_EN = 15'h0083;
    localparam logic [14:0] REG_PLL_STAT = 15'h0084;
    localparam logic [14:0] REG_PLL_FB = 15'h0085;
    localparam logic [14:0] REG_LF_A = 15'h0087;
    localparam logic [14:0] REG_LF_B = 15'h0088;
    localparam logic [14:0] REG_LF_C = 15'h0089;
    localparam logic [14:0] REG_CP_A = 15'h008A;
    localparam logic [14:0] REG_VCO_DIV = 15'h008B;
    localparam logic [14:0] REG_REF_DIV = 15'h008C;
    localparam logic [14:0] REG_PLL_REG = 15'h008D;
    localparam logic [14:0] REG_FORMAT = 15'h0110;
    localparam logic [14:0] REG_INTERP = 15'h0112;
    localparam logic [14:0] REG_DP_A = 15'h012D;
    localparam logic [14:0] REG_TEMP_EN = 15'h012F;
    localparam logic [14:0] REG_TEMP_LO = 15'h0132;
    localparam logic [14:0] REG_TEMP_HI = 15'h0133;
    localparam logic [14:0] REG_TEMP_LATCH = 15'h0134;
    localparam logic [14:0] REG_DP_B = 15'h0146;
    localparam logic [14:0] REG_PLL_BLK_PWR = 15'h01B0;
    localparam logic [14:0] REG_LUT_A = 15'h01B5;
    localparam logic [14:0] REG_CP_B = 15'h01B9;
    localparam logic [14:0] REG_LUT_B = 15'h01BB;
    localparam logic [14:0] REG_VCO_CTL = 15'h01BC;
    localparam logic [14:0] REG_VCO_PWR = 15'h01BE;
    localparam logic [14:0] REG_VCO_CAL = 15'h01BF;
    localparam logic [14:0] REG_LOCK_LEN = 15'h01C0;
    localparam logic [14:0] REG_CP_C = 15'h01C1;
    localparam logic [14:0] REG_VARACTOR = 15'h01C4;
    localparam logic [14:0] REG_LUT_C = 15'h01C5;
    localparam logic [14:0] REG_LANE_A = 15'h0232;
    localparam logic [14:0] REG_CLK_CFG = 15'h02A4;
    localparam logic [14:0] REG_LANE_B = 15'h0333;
    localparam int NUM_STEPS = 37;
    localparam logic [5:0] STEP_POLL = 6'h20;
    localparam logic [5:0] STEP_LAST = 6'h24;
    localparam int PLL_LOCK_BIT = 1;
    localparam int TEMP_BIT = 0;
    localparam logic [7:0] ONE_BIT = 8'h01;
    localparam int SCLK_HALF_NS = 50;
    localparam int CLK_NS = 10;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS = 24;
    localparam int POLL_LIMIT = 64;
    localparam int POLL_GAP_CYC = 100;
    // kind of a step: write, read-and-check lock, plain read
    typedef enum logic [1:0] {DSS_WR, DSS_POLL, DSS_RD} dss_kind_t;
endpackage

// ### src/dss_sequencer.sv
/*
 host sequencer: drives the converter's 4-wire serial port through start-up,
 polls pll lock with a bound, then offers temperature reads on request.
 assumes the device samples sdio on rising sclk and drives sdo on falling.
*/
// What this block does
// - enable temperature sensor before any reading
// - latch temperature, then read two code bytes
// - soft reset 0xBD, then 0x3C four-wire
// - write 0x28 to power control
// - write zero to both clock power registers
// - required datapath, clock and lane writes
// - loop filter 0x62, 0xC9, 0x0E in order
// - charge pumps 0x12, 0x24, 0x2A
// - vco 0x0D,0x02,0x8E; regulator 0x7B, varactor 0x7E
// - lock counter length 0x2A
// - pll block power written zero
// - vco output divide 0x02, divide by 8
// - reference divide 0x03, divide by 8
// - feedback counter 0x10
// - lookup values 0x09, 0x13, 0x06
// - enable pll 0x10, confirm lock bit 1
// - interpolation register written zero
// - data format written zero, twos complement
// - start-up before datapath, then later link steps
// - quick link bring-up is debug only
`timescale 1ns/1ps
module dss_sequencer #(
    parameter int POLL_MAX = dss_pkg::POLL_LIMIT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic temp_req,
    output logic busy,
    output logic done,
    output logic lock_fail,
    output logic temp_valid,
    output logic [15:0] temp_code,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdio,
    input wire logic spi_sdo
);
    typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_NEXT, ST_GAP, ST_READY, ST_FAIL} dss_state_t;
    typedef struct packed {
        dss_state_t st;
        logic [5:0] step;
        logic [2:0] tstep;
        logic tmode;
        logic [4:0] bit_cnt;
        logic [3:0] div;
        logic [23:0] shreg;
        logic [7:0] rdata;
        logic [7:0] poll_cnt;
        logic [7:0] gap;
        logic sclk;
        logic cs_n;
        logic sdio;
        logic busy;
        logic done;
        logic fail;
        logic tvalid;
        logic [15:0] tcode;
        logic [1:0] sdo_sync;
    } dss_regs_t;

    dss_regs_t r, n;
    logic [14:0] s_addr;
    logic [7:0] s_val;
    dss_pkg::dss_kind_t s_kind;

    // start-up table, order fixed
    always_comb begin
        s_kind = dss_pkg::DSS_WR;
        s_val = 8'h00;
        s_addr = dss_pkg::REG_IFACE_CFG;
        if (r.tmode) begin
            case (r.tstep)
                3'h0: begin s_addr = dss_pkg::REG_TEMP_EN; s_val = dss_pkg::ONE_BIT; end
                3'h1: begin s_addr = dss_pkg::REG_TEMP_LATCH; s_val = dss_pkg::ONE_BIT; end
                3'h2: begin s_addr = dss_pkg::REG_TEMP_LO; s_kind = dss_pkg::DSS_RD; end
                default: begin s_addr = dss_pkg::REG_TEMP_HI; s_kind = dss_pkg::DSS_RD; end
            endcase
        end else begin
            case (r.step)
                6'h00: begin s_addr = dss_pkg::REG_IFACE_CFG; s_val = 8'hBD; end
                6'h01: begin s_addr = dss_pkg::REG_IFACE_CFG; s_val = 8'h3C; end
                6'h02: begin s_addr = dss_pkg::REG_BIAS_PWR; s_val = 8'h28; end
                6'h03: begin s_addr = dss_pkg::REG_CLK_PWR; s_val = 8'h00; end
                6'h04: begin s_addr = dss_pkg::REG_SYNC_PWR; s_val = 8'h00; end
                6'h05: begin s_addr = dss_pkg::REG_DP_A; s_val = 8'h8B; end
                6'h06: begin s_addr = dss_pkg::REG_DP_B; s_val = 8'h01; end
                6'h07: begin s_addr = dss_pkg::REG_CLK_CFG; s_val = 8'hFF; end
                6'h08: begin s_addr = dss_pkg::REG_LANE_A; s_val = 8'hFF; end
                6'h09: begin s_addr = dss_pkg::REG_LANE_B; s_val = 8'h01; end
                6'h0A: begin s_addr = dss_pkg::REG_LF_A; s_val = 8'h62; end
                6'h0B: begin s_addr = dss_pkg::REG_LF_B; s_val = 8'hC9; end
                6'h0C: begin s_addr = dss_pkg::REG_LF_C; s_val = 8'h0E; end
                6'h0D: begin s_addr = dss_pkg::REG_CP_A; s_val = 8'h12; end
                6'h0E: begin s_addr = dss_pkg::REG_PLL_REG; s_val = 8'h7B; end
                6'h0F: begin s_addr = dss_pkg::REG_PLL_BLK_PWR; s_val = 8'h00; end
                6'h10: begin s_addr = dss_pkg::REG_CP_B; s_val = 8'h24; end
                6'h11: begin s_addr = dss_pkg::REG_VCO_CTL; s_val = 8'h0D; end
                6'h12: begin s_addr = dss_pkg::REG_VCO_PWR; s_val = 8'h02; end
                6'h13: begin s_addr = dss_pkg::REG_VCO_CAL; s_val = 8'h8E; end
                6'h14: begin s_addr = dss_pkg::REG_LOCK_LEN; s_val = 8'h2A; end
                6'h15: begin s_addr = dss_pkg::REG_CP_C; s_val = 8'h2A; end
                6'h16: begin s_addr = dss_pkg::REG_VARACTOR; s_val = 8'h7E; end
                6'h17: begin s_addr = dss_pkg::REG_VCO_DIV; s_val = 8'h02; end
                6'h18: begin s_addr = dss_pkg::REG_REF_DIV; s_val = 8'h03; end
                6'h19: begin s_addr = dss_pkg::REG_PLL_FB; s_val = 8'h10; end
                6'h1A: begin s_addr = dss_pkg::REG_LUT_A; s_val = 8'h09; end
                6'h1B: begin s_addr = dss_pkg::REG_LUT_B; s_val = 8'h13; end
                6'h1C: begin s_addr = dss_pkg::REG_LUT_C; s_val = 8'h06; end
                6'h1D: begin s_addr = dss_pkg::REG_PLL_EN; s_val = 8'h10; end
                6'h1E: begin s_addr = dss_pkg::REG_PLL_STAT; s_kind = dss_pkg::DSS_POLL; end
                6'h1F: begin s_addr = dss_pkg::REG_PLL_STAT; s_kind = dss_pkg::DSS_POLL; end
                6'h20: begin s_addr = dss_pkg::REG_PLL_STAT; s_kind = dss_pkg::DSS_POLL; end
                6'h21: begin s_addr = dss_pkg::REG_INTERP; s_val = 8'h00; end
                6'h22: begin s_addr = dss_pkg::REG_FORMAT; s_val = 8'h00; end
                6'h23: begin s_addr = dss_pkg::REG_TEMP_EN; s_val = dss_pkg::ONE_BIT; end
                6'h24: begin s_addr = dss_pkg::REG_TEMP_EN; s_val = dss_pkg::ONE_BIT; end
                default: begin s_addr = dss_pkg::REG_IFACE_CFG; s_val = 8'h00; end
            endcase
        end
    end

    always_comb begin
        logic rd;
        rd = 1'b0;
        n = r;
        n.sdo_sync = {r.sdo_sync[0], spi_sdo};
        case (r.st)
            ST_IDLE: begin
                n.cs_n = 1'b1;
                n.sclk = 1'b0;
                if (start) begin
                    n.st = ST_NEXT;
                    n.step = 6'h00;
                    n.busy = 1'b1;
                    n.done = 1'b0;
                    n.poll_cnt = 8'h00;
                end
            end
            ST_NEXT: begin
                // frame: r/w bit, 15-bit address, 8 data bits
                rd = (s_kind != dss_pkg::DSS_WR);
                n.shreg = {rd, s_addr, s_val};
                n.cs_n = 1'b0;
                n.sdio = rd;
                n.bit_cnt = 5'h00;
                n.div = 4'h0;
                n.sclk = 1'b0;
                n.st = ST_SHIFT;
            end
            ST_SHIFT: begin
                // sclk well below the port limit; two half periods per bit
                if (r.div == 4'(dss_pkg::SCLK_HALF_CYC - 1)) begin
                    n.div = 4'h0;
                    n.sclk = ~r.sclk;
                    if (r.sclk) begin
                        n.shreg = {r.shreg[22:0], 1'b0};
                        n.sdio = r.shreg[22];
                        n.bit_cnt = r.bit_cnt + 5'h01;
                        if (r.bit_cnt == 5'(dss_pkg::FRAME_BITS - 1)) begin
                            n.sclk = 1'b0;
                            n.cs_n = 1'b1;
                            n.gap = 8'h00;
                            n.st = ST_GAP;
                        end
                    end else begin
                        n.rdata = {r.rdata[6:0], r.sdo_sync[1]};
                    end
                end else begin
                    n.div = r.div + 4'h1;
                end
            end
            ST_GAP: begin
                n.gap = r.gap + 8'h01;
                if (r.tmode) begin
                    if (r.gap == 8'h01) begin
                        if (r.tstep == 3'h2) n.tcode[7:0] = r.rdata;
                        if (r.tstep == 3'h3) begin
                            n.tcode[15:8] = r.rdata;
                            n.tvalid = 1'b1;
                            n.tmode = 1'b0;
                            n.st = ST_READY;
                        end else begin
                            n.tstep = r.tstep + 3'h1;
                            n.st = ST_NEXT;
                        end
                    end
                end else if (s_kind == dss_pkg::DSS_POLL) begin
                    // spacing between polls; first two reads only allow settling
                    if (r.gap == 8'(dss_pkg::POLL_GAP_CYC)) begin
                        if (r.step < dss_pkg::STEP_POLL) begin
                            n.step = r.step + 6'h01;
                            n.st = ST_NEXT;
                        end else if (r.rdata[dss_pkg::PLL_LOCK_BIT]) begin
                            n.step = r.step + 6'h01;
                            n.st = ST_NEXT;
                        end else if (r.poll_cnt == 8'(POLL_MAX - 1)) begin
                            n.fail = 1'b1;
                            n.busy = 1'b0;
                            n.st = ST_FAIL;
                        end else begin
                            n.poll_cnt = r.poll_cnt + 8'h01;
                            n.st = ST_NEXT;
                        end
                    end
                end else if (r.gap == 8'h01) begin
                    if (r.step == dss_pkg::STEP_LAST) begin
                        // link layers follow in other logic; not done here
                        n.busy = 1'b0;
                        n.done = 1'b1;
                        n.st = ST_READY;
                    end else begin
                        n.step = r.step + 6'h01;
                        n.st = ST_NEXT;
                    end
                end
            end
            ST_READY: begin
                n.busy = 1'b0;
                if (temp_req) begin
                    n.tmode = 1'b1;
                    n.tstep = 3'h1; // sensor already enabled at start-up
                    n.tvalid = 1'b0;
                    n.busy = 1'b1;
                    n.st = ST_NEXT;
                end
            end
            ST_FAIL: begin
                n.cs_n = 1'b1;
                if (start) begin
                    n.fail = 1'b0;
                    n.busy = 1'b1;
                    n.step = 6'h00;
                    n.poll_cnt = 8'h00;
                    n.st = ST_NEXT;
                end
            end
            default: n.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.cs_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
    assign lock_fail = r.fail;
    assign temp_valid = r.tvalid;
    assign temp_code = r.tcode;
    assign spi_sclk = r.sclk;
    assign spi_cs_n = r.cs_n;
    assign spi_sdio = r.sdio;

    a_fail_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(r.fail) |-> r.poll_cnt == 8'(POLL_MAX - 1))
        else $error("lock failure before poll limit");
    a_reset_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.st == ST_SHIFT && r.step == 6'h00 && !r.tmode && r.bit_cnt == 5'h00)
        |-> r.shreg[7:0] == 8'hBD || r.div != 4'h0 || r.sclk)
        else $error("first frame is not the soft reset");
    a_done_after: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(r.done) |-> $past(r.step) == dss_pkg::STEP_LAST)
        else $error("done before table end");
    a_cs_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.st == ST_READY |-> r.cs_n)
        else $error("chip select low while idle");
    a_temp_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(r.tvalid) |-> $past(r.tstep) == 3'h3)
        else $error("temperature valid without high byte");
    a_lock_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($past(r.step) == dss_pkg::STEP_POLL && r.step == 6'h21 && !r.tmode)
        |-> $past(r.rdata[dss_pkg::PLL_LOCK_BIT]))
        else $error("left poll without lock");
    a_frame_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(r.cs_n) |-> $past(r.bit_cnt) == 5'(dss_pkg::FRAME_BITS - 1))
        else $error("frame not 24 bits");
    a_no_early_temp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.tmode |-> r.step == dss_pkg::STEP_LAST)
        else $error("temperature before sensor enable");
    // framing: device samples on rising sclk, so sdio may move only while low
    a_sclk_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.cs_n |-> !r.sclk)
        else $error("sclk high outside a frame");
    a_sdio_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!r.cs_n && r.sclk) |-> $stable(r.sdio))
        else $error("sdio moved while sclk high");
    a_cmd_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.st == ST_SHIFT && r.bit_cnt == 5'h00 && !r.sclk) |-> r.sdio == r.shreg[23])
        else $error("first bit is not the read flag");
    a_bit_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.st == ST_SHIFT |-> r.bit_cnt < 5'(dss_pkg::FRAME_BITS))
        else $error("bit count past frame end");
    a_div_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.st == ST_SHIFT |-> r.div < 4'(dss_pkg::SCLK_HALF_CYC))
        else $error("sclk divider out of range");
    a_frame_open: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.st == ST_NEXT |=> r.st == ST_SHIFT && !r.cs_n && !r.sclk)
        else $error("frame did not open after load");
    a_cs_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(r.cs_n) |-> $past(r.st) == ST_NEXT)
        else $error("chip select fell outside frame start");
    a_cs_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(r.cs_n) |=> r.cs_n ##1 r.cs_n)
        else $error("chip select high gap too short");
    // lock polling: the spacing gives the pll time to settle between reads
    a_poll_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.st == ST_GAP && !r.tmode && s_kind == dss_pkg::DSS_POLL
        && r.gap < 8'(dss_pkg::POLL_GAP_CYC)) |=> r.st == ST_GAP)
        else $error("poll issued before spacing elapsed");
    a_lock_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.st == ST_GAP && !r.tmode && r.step == dss_pkg::STEP_POLL && r.rdata[1]
        && r.gap == 8'(dss_pkg::POLL_GAP_CYC)) |=> r.step == 6'h21)
        else $error("lock seen but sequence did not advance");
    a_done_fail: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.done |-> !r.fail)
        else $error("done and lock failure together");
    a_fail_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.st == ST_FAIL |-> r.cs_n && !r.sclk && !r.busy)
        else $error("port active after lock failure");
    a_gap_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.st == ST_GAP && !r.tmode && s_kind == dss_pkg::DSS_WR && r.gap == 8'h01
        && r.step != dss_pkg::STEP_LAST) |=> r.st == ST_NEXT && r.step == $past(r.step) + 6'h01)
        else $error("table step skipped");
    a_busy_frames: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.st inside {ST_NEXT, ST_SHIFT, ST_GAP} |-> r.busy)
        else $error("frame without busy");
    // temperature path: both bytes come from one latch, so they must pair
    a_lo_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.tmode && r.st == ST_GAP && r.tstep == 3'h2 && r.gap == 8'h01)
        |=> r.tcode[7:0] == $past(r.rdata))
        else $error("low temperature byte not taken");
    a_hi_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(r.tvalid) |-> r.tcode[15:8] == $past(r.rdata))
        else $error("high temperature byte not taken");
    a_code_stands: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.tvalid && $past(r.tvalid)) |-> $stable(r.tcode))
        else $error("temperature code changed while valid");
    c_done: cover property (@(posedge sys_clk) $rose(r.done));
    c_fail: cover property (@(posedge sys_clk) $rose(r.fail));
    c_temp: cover property (@(posedge sys_clk) $rose(r.tvalid));
    c_retry: cover property (@(posedge sys_clk) r.st == ST_NEXT && r.poll_cnt == 8'h01);
    c_restart: cover property (@(posedge sys_clk) $past(r.st) == ST_FAIL && r.st == ST_NEXT);
endmodule // dss_sequencer

// ### bench/dss_dev_model.sv
/*
 behavioural model of the converter's 4-wire serial port and the registers
 the start-up sequencer touches. assumes sdio is sampled on rising sclk and
 sdo is driven on falling sclk, 24-bit frames, msb first.
*/
`timescale 1ns/1ps
module dss_dev_model #(
    parameter int LOCK_AFTER = 3,
    parameter logic [15:0] TEMP_CODE = 16'hA5C3
) (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio,
    input wire logic lock_en,
    output logic sdo
);
    logic [7:0] regs [logic [14:0]];
    logic [22:0] wr_q [$];
    logic [23:0] sh;
    logic [7:0] rdata;
    logic latched;
    logic pll_on;
    int cnt;
    int polls;

    initial begin
        sdo = 1'b0;
        sh = '0;
        rdata = '0;
        latched = 1'b0;
        pll_on = 1'b0;
        cnt = 0;
        polls = 0;
    end

    always @(negedge cs_n) cnt = 0;
    // deselected: show the inverse so a stale bit never reads as valid
    always @(posedge cs_n) sdo = ~sdo;

    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = {sh[22:0], sdio};
            cnt = cnt + 1;
            if (cnt == 16 && sh[15]) begin
                case (sh[14:0])
                    dss_pkg::REG_PLL_STAT: begin
                        polls = polls + 1;
                        rdata = {6'h00, lock_en && pll_on && polls >= LOCK_AFTER, 1'b0};
                    end
                    dss_pkg::REG_TEMP_LO: rdata = latched ? TEMP_CODE[7:0] : 8'h00;
                    dss_pkg::REG_TEMP_HI: rdata = latched ? TEMP_CODE[15:8] : 8'h00;
                    default: rdata = regs.exists(sh[14:0]) ? regs[sh[14:0]] : 8'h00;
                endcase
            end
            if (cnt == 24 && !sh[23]) begin
                wr_q.push_back(sh[22:0]);
                regs[sh[22:8]] = sh[7:0];
                if (sh[22:8] == dss_pkg::REG_PLL_EN) begin
                    pll_on = (sh[7:0] == 8'h10);
                    polls = 0;
                end
                // a latch without the sensor enabled yields no code
                if (sh[22:8] == dss_pkg::REG_TEMP_LATCH && sh[0]) begin
                    latched = regs.exists(dss_pkg::REG_TEMP_EN) && regs[dss_pkg::REG_TEMP_EN][0];
                end
            end
        end
    end

    always @(negedge sclk) begin
        if (!cs_n && cnt >= 16 && cnt < 24) begin
            sdo = rdata[23 - cnt];
        end
    end
endmodule // dss_dev_model

// ### bench/dss_sequencer_test.sv
/*
 self-checking bench for the start-up sequencer: a failed lock, a full
 bring-up and two temperature reads. assumes the device model in dss_dev_model.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module dss_sequencer_test;
    localparam logic [22:0] EXP_TAB [33] = '{
        23'h000BD, 23'h0003C, 23'h01128, 23'h08000, 23'h08100, 23'h12D8B, 23'h14601,
        23'h2A4FF, 23'h232FF, 23'h33301, 23'h08762, 23'h088C9, 23'h0890E, 23'h08A12,
        23'h08D7B, 23'h1B000, 23'h1B924, 23'h1BC0D, 23'h1BE02, 23'h1BF8E, 23'h1C02A,
        23'h1C12A, 23'h1C47E, 23'h08B02, 23'h08C03, 23'h08510, 23'h1B509, 23'h1BB13,
        23'h1C506, 23'h08310, 23'h11200, 23'h11000, 23'h12F01};
    localparam logic [15:0] TCODE = 16'hA5C3;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic temp_req = 1'b0;
    logic lock_en = 1'b0;
    logic busy, done, lock_fail, temp_valid, spi_sclk, spi_cs_n, spi_sdio, spi_sdo;
    logic [15:0] temp_code;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    dss_sequencer #(.POLL_MAX(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .start(start),
        .temp_req(temp_req), .busy(busy), .done(done), .lock_fail(lock_fail),
        .temp_valid(temp_valid), .temp_code(temp_code), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdio(spi_sdio), .spi_sdo(spi_sdo));
    dss_dev_model #(.LOCK_AFTER(3), .TEMP_CODE(TCODE)) i_dev (.sclk(spi_sclk),
        .cs_n(spi_cs_n), .sdio(spi_sdio), .lock_en(lock_en), .sdo(spi_sdo));

    always #5 sys_clk = ~sys_clk;

    task automatic results();
        $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // budget: two start-up runs of about 10k cycles plus temperature reads
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 50000) begin
            miscompares++;
            results();
        end
    end

    task automatic run_start();
        int i;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        @(posedge sys_clk);
        for (i = 0; i < 30000 && done !== 1'b1 && lock_fail !== 1'b1; i++) @(posedge sys_clk);
    endtask

    task automatic test_lock_fail();
        int i;
        lock_en <= 1'b0;
        i_dev.wr_q.delete();
        run_start();
        `CHK(lock_fail, 1'b1, "lock failure not flagged")
        `CHK(done, 1'b0, "done without lock")
        `CHK(i_dev.wr_q.size(), 30, "writes continued after lock failure")
        `CHK(i_dev.polls, 6, "lock polled past limit")
        for (i = 0; i < 30; i++) begin
            `CHK(i_dev.wr_q[i], EXP_TAB[i], "start-up write out of order")
        end
        temp_req <= 1'b1;
        @(posedge sys_clk);
        temp_req <= 1'b0;
        repeat (5) @(posedge sys_clk);
        `CHK({busy, spi_cs_n}, 2'b01, "temperature read taken when not ready")
    endtask

    task automatic test_bringup();
        int i;
        lock_en <= 1'b1;
        i_dev.wr_q.delete();
        run_start();
        `CHK({done, lock_fail}, 2'b10, "bring-up did not complete")
        `CHK(i_dev.polls >= 3, 1'b1, "done before lock was read back")
        `CHK(i_dev.wr_q.size() >= 33, 1'b1, "too few start-up writes")
        `CHK(i_dev.wr_q.size(), 34, "link-layer writes issued")
        for (i = 0; i < 33; i++) begin
            `CHK(i_dev.wr_q[i], EXP_TAB[i], "bring-up write wrong")
        end
    endtask

    task automatic test_temp();
        int i;
        int k;
        for (k = 0; k < 2; k++) begin
            temp_req <= 1'b1;
            @(posedge sys_clk);
            temp_req <= 1'b0;
            @(posedge sys_clk);
            for (i = 0; i < 3000 && temp_valid !== 1'b1; i++) @(posedge sys_clk);
            `CHK(temp_valid, 1'b1, "temperature read never completed")
            `CHK(temp_code, TCODE, "temperature code wrong")
            `CHK(i_dev.wr_q[$], 23'h13401, "latch not written before read")
        end
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        `CHK({spi_cs_n, spi_sclk, busy, done}, 4'b1000, "idle state after reset")
        test_lock_fail();
        test_bringup();
        test_temp();
        results();
    end
endmodule // dss_sequencer_test
